// file: verilog/ccce_pkg.sv
// constants for the clear/call/complement execute slice
package ccce_pkg;
   localparam int          INSTR_W         = 14;
   localparam int          PC_W            = 13;
   localparam int          FADDR_W         = 7;
   localparam int          DATA_W          = 8;
   localparam int          DOG_W           = 8;
   localparam int          PRESC_W         = 8;
   localparam int          STACK_DEPTH     = 8;
   localparam int          SP_W            = 3;
   // opcode fields
   localparam logic [5:0]  OPC_CLEAR_FILE  = 6'h01;   // 00 0001, d=1
   localparam logic [5:0]  OPC_INVERT_FILE = 6'h09;   // 00 1001
   localparam logic [2:0]  OPC_CALL        = 3'h4;    // 10 0
   localparam logic [13:0] ENC_CLEAR_WORK  = 14'h0103;
   localparam logic [13:0] ENC_DOG_CLEAR   = 14'h0064;
   localparam int          DBIT_POS        = 7;
   localparam int          LATCH_LO        = 3;
   localparam int          LATCH_HI        = 4;
   localparam int          CALL_CYCLES     = 2;
   // reset values
   localparam logic [PC_W-1:0]    PC_RST   = 13'h0000;
   localparam logic [DATA_W-1:0]  W_RST    = 8'h00;
   localparam logic [DOG_W-1:0]   DOG_ZERO = 8'h00;
   localparam logic [PRESC_W-1:0] PRE_ZERO = 8'h00;
   localparam logic               FLAG_RST = 1'b1;

   typedef enum logic [2:0] {
      CCCE_OP_NONE        = 3'b000,
      CCCE_OP_CLEAR_FILE  = 3'b001,
      CCCE_OP_CLEAR_WORK  = 3'b010,
      CCCE_OP_CALL        = 3'b011,
      CCCE_OP_DOG_CLEAR   = 3'b100,
      CCCE_OP_INVERT_FILE = 3'b101
   } ccce_op_e;
endpackage

// file: verilog/ccce_decode.sv
// instruction word classifier for the execute slice
module ccce_decode
   import ccce_pkg::*;
(
   input  wire logic [INSTR_W-1:0] instr_i,   // instruction word
   output ccce_op_e                op_o       // decoded operation
);
   always_comb
   begin
      op_o = CCCE_OP_NONE;
      if (instr_i == ENC_CLEAR_WORK)
         op_o = CCCE_OP_CLEAR_WORK;
      else if (instr_i == ENC_DOG_CLEAR)
         op_o = CCCE_OP_DOG_CLEAR;
      else if (instr_i[13:8] == OPC_CLEAR_FILE && instr_i[DBIT_POS])
         op_o = CCCE_OP_CLEAR_FILE;
      else if (instr_i[13:8] == OPC_INVERT_FILE)
         op_o = CCCE_OP_INVERT_FILE;
      else if (instr_i[13:11] == OPC_CALL)
         op_o = CCCE_OP_CALL;
   end
endmodule // ccce_decode

// file: verilog/ccce_exec.sv
// execute slice: clear file, call, clear work, watchdog clear, invert file
module ccce_exec
   import ccce_pkg::*;
(
   input  wire logic               clk_i,            // instruction clock
   input  wire logic               nrst_i,           // async reset, active low
   input  wire logic               instr_valid_i,    // instruction word present
   input  wire logic [INSTR_W-1:0] instr_i,          // instruction word
   input  wire logic [DATA_W-1:0]  file_rdata_i,     // addressed register contents
   input  wire logic [DATA_W-1:0]  upper_pc_latch_i, // upper pc latch register
   input  wire logic               watchdog_tick_i,  // watchdog prescaler clock tick
   output logic                    busy_o,           // second cycle of a call
   output logic [PC_W-1:0]         pc_o,             // program counter
   output logic [PC_W-1:0]         stack_top_o,      // stack top
   output logic [SP_W-1:0]         sp_o,             // stack pointer
   output logic                    file_we_o,        // file register write strobe
   output logic [FADDR_W-1:0]      file_addr_o,      // file register address
   output logic [DATA_W-1:0]       file_wdata_o,     // file register write data
   output logic [DATA_W-1:0]       work_o,           // working register
   output logic                    zero_flag_o,      // zero flag
   output logic                    timeout_flag_o,   // timeout status bit
   output logic                    powerdown_flag_o, // power-down status bit
   output logic [DOG_W-1:0]        watchdog_counter_o, // watchdog counter
   output logic [PRESC_W-1:0]      watchdog_prescale_o // watchdog prescaler
);
   ccce_op_e                op;
   logic                    exec;
   logic [DATA_W-1:0]       inv;
   logic [PC_W-1:0]         stack_q [STACK_DEPTH];
   logic [PRESC_W-1:0]      pre_inc;

   ////////////////////////////////////////////////////////////////////////
   ccce_decode u_dec (
      .instr_i (instr_i),
      .op_o    (op)
   );

   // the fetched word is ignored during the call's second cycle
   assign exec    = instr_valid_i && !busy_o;
   assign inv     = ~file_rdata_i;
   assign pre_inc = watchdog_prescale_o + 8'h01;

   ////////////////////////////////////////////////////////////////////////
   // program counter and call sequencing
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pc_o   <= PC_RST;
         busy_o <= 1'b0;
      end
      else if (busy_o)
      begin
         busy_o <= 1'b0;
      end
      else if (exec && op == CCCE_OP_CALL)
      begin
         pc_o   <= {upper_pc_latch_i[LATCH_HI:LATCH_LO], instr_i[10:0]};
         busy_o <= 1'b1;
      end
      else if (exec)
      begin
         pc_o <= pc_o + 13'h0001;
      end
   end

   // return stack: circular, overflow wraps silently; nothing pops in this slice
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sp_o        <= '0;
         stack_top_o <= PC_RST;
      end
      else if (exec && op == CCCE_OP_CALL)
      begin
         stack_top_o <= pc_o + 13'h0001;
         sp_o        <= sp_o + 3'h1;
      end
   end

   // stack storage has no reset: an entry is only meaningful after its push
   always_ff @(posedge clk_i)
   begin
      if (exec && op == CCCE_OP_CALL)
         stack_q[sp_o] <= pc_o + 13'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // file register writes
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         file_we_o    <= 1'b0;
         file_addr_o  <= '0;
         file_wdata_o <= '0;
      end
      else
      begin
         file_we_o   <= 1'b0;
         file_addr_o <= instr_i[FADDR_W-1:0];
         if (exec && op == CCCE_OP_CLEAR_FILE)
         begin
            file_we_o    <= 1'b1;
            file_wdata_o <= 8'h00;
         end
         else if (exec && op == CCCE_OP_INVERT_FILE && instr_i[DBIT_POS])
         begin
            file_we_o    <= 1'b1;
            file_wdata_o <= inv;
         end
      end
   end

   // working register
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         work_o <= W_RST;
      else if (exec && op == CCCE_OP_CLEAR_WORK)
         work_o <= 8'h00;
      else if (exec && op == CCCE_OP_INVERT_FILE && !instr_i[DBIT_POS])
         work_o <= inv;
   end

   // zero flag; call leaves it alone
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         zero_flag_o <= 1'b0;
      else if (exec && (op == CCCE_OP_CLEAR_FILE || op == CCCE_OP_CLEAR_WORK))
         zero_flag_o <= 1'b1;
      else if (exec && op == CCCE_OP_INVERT_FILE)
         zero_flag_o <= (inv == 8'h00);
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog: prescaler divides ticks, counter steps on prescaler wrap
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         watchdog_counter_o  <= DOG_ZERO;
         watchdog_prescale_o <= PRE_ZERO;
      end
      else if (exec && op == CCCE_OP_DOG_CLEAR)
      begin
         watchdog_counter_o  <= DOG_ZERO;
         watchdog_prescale_o <= PRE_ZERO;
      end
      else if (watchdog_tick_i)
      begin
         watchdog_prescale_o <= pre_inc;
         if (pre_inc == PRE_ZERO)
            watchdog_counter_o <= watchdog_counter_o + 8'h01;
      end
   end

   // status bits; only the watchdog clear touches them in this slice,
   // time-out and sleep clear them elsewhere in the core
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         timeout_flag_o   <= FLAG_RST;
         powerdown_flag_o <= FLAG_RST;
      end
      else if (exec && op == CCCE_OP_DOG_CLEAR)
      begin
         timeout_flag_o   <= 1'b1;
         powerdown_flag_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_clear_file: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_CLEAR_FILE |=> file_we_o && file_wdata_o == 8'h00 && zero_flag_o)
      else $error("clear file did not write zero and set Z");

   a_call_push: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_CALL |=> stack_top_o == $past(pc_o) + 13'h0001)
      else $error("call pushed wrong return address");

   a_stack_entry: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_CALL |=> stack_q[sp_o - 3'h1] == stack_top_o)
      else $error("stack entry differs from stack top");

   a_call_target: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_CALL |=>
      pc_o == {$past(upper_pc_latch_i[LATCH_HI:LATCH_LO]), $past(instr_i[10:0])})
      else $error("call loaded wrong pc");

   a_call_two_cyc: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_CALL |=> busy_o && $stable(zero_flag_o) ##1 !busy_o)
      else $error("call not two cycles or flag changed");

   a_dog_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_DOG_CLEAR |=>
      watchdog_counter_o == 8'h00 && watchdog_prescale_o == 8'h00)
      else $error("watchdog not cleared");

   a_dog_flags: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && instr_i == ENC_DOG_CLEAR |=> timeout_flag_o && powerdown_flag_o)
      else $error("status bits not set by watchdog clear");

   a_invert_work: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_INVERT_FILE && !instr_i[DBIT_POS] |=>
      work_o == ~$past(file_rdata_i) && !file_we_o)
      else $error("invert to W wrong");

   a_invert_file: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_INVERT_FILE && instr_i[DBIT_POS] |=>
      file_we_o && file_wdata_o == ~$past(file_rdata_i) && $stable(work_o))
      else $error("invert to file wrong");

   a_clear_work: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && instr_i == ENC_CLEAR_WORK |=> work_o == 8'h00 && zero_flag_o)
      else $error("clear work failed");

   a_invert_zflag: assert property (@(posedge clk_i) disable iff (!nrst_i)
      exec && op == CCCE_OP_INVERT_FILE |=> zero_flag_o == ($past(file_rdata_i) == 8'hff))
      else $error("invert zero flag wrong");
endmodule // ccce_exec

// file: testbench/ccce_exec_tb.sv
// self-checking bench for the execute slice
module ccce_exec_tb
   import ccce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk_i = 1'b0;
   logic               nrst_i = 1'b0;
   logic               instr_valid_i = 1'b0;
   logic [INSTR_W-1:0] instr_i = 14'h0000;
   logic [DATA_W-1:0]  file_rdata_i = 8'h00;
   logic [DATA_W-1:0]  upper_pc_latch_i = 8'h00;
   logic               watchdog_tick_i = 1'b0;
   logic               busy_o, file_we_o, zero_flag_o, timeout_flag_o, powerdown_flag_o;
   logic [PC_W-1:0]    pc_o, stack_top_o, exp_pc;
   logic [SP_W-1:0]    sp_o;
   logic [FADDR_W-1:0] file_addr_o;
   logic [DATA_W-1:0]  file_wdata_o, work_o, watchdog_counter_o, watchdog_prescale_o;
   int                 failures = 0;
   int                 check_count = 0;
   always #2.5 clk_i = ~clk_i;
   ccce_exec dut (.clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .file_rdata_i(file_rdata_i), .upper_pc_latch_i(upper_pc_latch_i),
      .watchdog_tick_i(watchdog_tick_i), .busy_o(busy_o), .pc_o(pc_o),
      .stack_top_o(stack_top_o),
      .sp_o(sp_o), .file_we_o(file_we_o), .file_addr_o(file_addr_o),
      .file_wdata_o(file_wdata_o), .work_o(work_o), .zero_flag_o(zero_flag_o),
      .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
      .watchdog_counter_o(watchdog_counter_o), .watchdog_prescale_o(watchdog_prescale_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one instruction, taken at the second edge; results sampled just after it
   task automatic run(input logic [INSTR_W-1:0] ins, input logic [DATA_W-1:0] rd);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i       <= ins;
      file_rdata_i  <= rd;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      exp_pc = exp_pc + 13'h0001;
      chk(16'(pc_o), 16'(exp_pc), "pc step");
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(5ns * 3000);
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      close_out();
   end
   // invert cases: word, read data, expected result, expected W afterwards
   logic [INSTR_W-1:0] inv_ins [4] = '{14'h0925, 14'h09a5, 14'h0925, 14'h0925};
   logic [DATA_W-1:0]  inv_rd  [4] = '{8'h13, 8'h5a, 8'hff, 8'h00};
   logic [DATA_W-1:0]  inv_res [4] = '{8'hec, 8'ha5, 8'h00, 8'hff};
   logic [DATA_W-1:0]  inv_w   [4] = '{8'hec, 8'hec, 8'h00, 8'hff};
   initial
   begin
      exp_pc = 13'h0000;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      #1;
      chk(16'(pc_o), 16'h0000, "reset pc");
      chk(16'({timeout_flag_o, powerdown_flag_o}), 16'h0003, "reset flags");
      for (int i = 0; i < 4; i++)
      begin
         run(inv_ins[i], inv_rd[i]);
         chk(16'(file_we_o), 16'(inv_ins[i][DBIT_POS]), "invert dest");
         chk(16'(work_o), 16'(inv_w[i]), "invert w");
         chk(16'(zero_flag_o), 16'(inv_res[i] == 8'h00), "invert z");
         if (inv_ins[i][DBIT_POS])
         begin
            chk(16'({file_addr_o, file_wdata_o}), 16'({7'h25, inv_res[i]}), "inv file");
         end
      end
      run(14'h01ff, 8'h5a);
      chk(16'({file_we_o, file_addr_o, file_wdata_o}), 16'hff00, "clear file");
      chk(16'(zero_flag_o), 16'h0001, "clear file z");
      run(14'h0925, 8'h5a);
      chk(16'({work_o, 7'h00, zero_flag_o}), 16'ha500, "set w");
      run(14'h0103, 8'h00);
      chk(16'({work_o, 7'h00, zero_flag_o}), 16'h0001, "clear work");
      // call held over the busy edge: the second copy must be swallowed
      @(posedge clk_i);
      upper_pc_latch_i <= 8'hef;
      instr_valid_i    <= 1'b1;
      instr_i          <= 14'h2005;
      @(posedge clk_i);
      #1;
      chk(16'(stack_top_o), 16'(exp_pc + 13'h0001), "call push");
      chk(16'(pc_o), 16'h0805, "call target");
      chk(16'({busy_o, sp_o, zero_flag_o}), 16'h0013, "call busy");
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      chk(16'({busy_o, sp_o, pc_o}), 16'h2805, "call second cycle");
      exp_pc = 13'h0805;
      @(posedge clk_i);
      watchdog_tick_i <= 1'b1;
      repeat (260) @(posedge clk_i);
      watchdog_tick_i <= 1'b0;
      #1;
      chk(16'(watchdog_prescale_o), 16'h0004, "prescaler runs");
      chk(16'(watchdog_counter_o), 16'h0001, "counter runs");
      run(14'h0064, 8'h00);
      chk(16'(watchdog_counter_o), 16'h0000, "watchdog clear");
      chk(16'(watchdog_prescale_o), 16'h0000, "prescaler clear");
      chk(16'({timeout_flag_o, powerdown_flag_o}), 16'h0003, "watchdog flags");
      close_out();
   end
endmodule // ccce_exec_tb
